// file: core/ums_pkg.sv
// ums_pkg: register indices, field positions, reset values and encodings
// for the modem status and flow control block.
// assumes: used with package::name everywhere, nothing imported.
package ums_pkg;
    // ------------------------------------------------------------
    // register indices (plain port, byte-wide registers)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_IEN   = 4'h1; // interrupt_enable
    localparam logic [3:0] ADDR_IST   = 4'h2; // interrupt_status (read)
    localparam logic [3:0] ADDR_FCTL  = 4'h2; // fifo_control (write)
    localparam logic [3:0] ADDR_LCTL  = 4'h3; // line_control
    localparam logic [3:0] ADDR_MCTL  = 4'h4; // modem_control
    localparam logic [3:0] ADDR_LST   = 4'h5; // line_status
    localparam logic [3:0] ADDR_MST   = 4'h6; // modem_line_status
    localparam logic [3:0] ADDR_SCR   = 4'h7; // scratch_byte
    localparam logic [3:0] ADDR_EFC   = 4'h8; // enhanced_feature_control
    localparam logic [3:0] ADDR_RES1  = 4'h9; // resume_char_first
    localparam logic [3:0] ADDR_RES2  = 4'hA; // resume_char_second
    localparam logic [3:0] ADDR_PAU1  = 4'hB; // pause_char_first
    localparam logic [3:0] ADDR_PAU2  = 4'hC; // pause_char_second
    localparam logic [3:0] ADDR_FLOW  = 4'hD; // flow state (read only)

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EFC_ENH      = 4;
    localparam int EFC_SPECIAL  = 5;
    localparam int EFC_AUTO_RTS = 6;
    localparam int EFC_AUTO_CTS = 7;
    localparam int MCTL_DTR     = 0;
    localparam int MCTL_RTS     = 1;
    localparam int MCTL_OUT1    = 2;
    localparam int MCTL_OUT2    = 3;
    localparam int MCTL_LOOP    = 4;
    localparam int IST_XOFF     = 4;

    // masks of enhanced (gated) bits
    localparam logic [7:0] IEN_ENH_MASK  = 8'hF0;
    localparam logic [7:0] IST_ENH_MASK  = 8'h30;
    localparam logic [7:0] FCTL_ENH_MASK = 8'h30;
    localparam logic [7:0] MCTL_ENH_MASK = 8'hE0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_IST  = 8'h01;
    localparam logic [7:0] RST_LST  = 8'h60;

    // software flow modes (two-bit field)
    typedef enum logic [1:0] {
        UMS_FLOW_NONE  = 2'h0,
        UMS_FLOW_FIRST = 2'h2,
        UMS_FLOW_SECOND= 2'h1,
        UMS_FLOW_BOTH  = 2'h3
    } ums_flow_t;
endpackage

// file: core/ums_sync.sv
// ums_sync: per-bit two-flop synchroniser for asynchronous pins.
// assumes: one clock, async active-high reset, clock enable.
`timescale 1ns/1ps
module ums_sync #(
    parameter int         WIDTH = 4,
    parameter logic [3:0] INIT  = 4'hF
) (
    input  wire logic             clock,  // system clock
    input  wire logic             rst,    // async reset
    input  wire logic             ce,     // clock enable
    input  wire logic [WIDTH-1:0] din,    // async input
    output logic      [WIDTH-1:0] dout    // synchronised
);
    initial begin
        if (WIDTH < 1 || WIDTH > 4) $error("ums_sync: WIDTH out of range");
    end
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    meta_r  <= INIT[i];
                    dout[i] <= INIT[i];
                end else if (ce) begin
                    meta_r  <= din[i];
                    dout[i] <= meta_r;
                end
            end
        end
    endgenerate
endmodule

// file: core/ums_core.sv
// ums_core: modem status, scratch, enhanced features and flow control.
// assumes: byte register port; rx byte stream and fifo level come from
// the receive path, tx side obeys tx_pause_r between characters.
`timescale 1ns/1ps
// Operation
// - cts, dsr, cd change sets flag
// - ring flag only on rising input
// - status read clears four change flags
// - any change flag raises modem interrupt
// - bits 4-7 show inverted input pins
// - loopback shows modem control outputs instead
// - scratch byte stores and returns data
// - feature bits 1:0 select rx char pairs
// - dual mode treats pairs as sequence
// - enhanced bit writes need feature bit4
// - clearing bit4 saves, setting restores
// - enhanced bits zero after reset
// - special detect compares second pause char
// - char bit0 matches received lsb
// - auto rts raises above trigger level
// - auto rts lowers below trigger minus one
// - rts follows control bit when off
// - auto cts pauses after current char
// - reset clears control regs, status bit0 one
// - line status 0x60, modem flags zero
// - control bit4 selects loopback
// - xoff flag holds until resume received
module ums_core #(
    parameter int         LVL_W = 5   // fifo level width (16-deep fifo)
) (
    input  wire logic             clock,        // 125 MHz clock
    input  wire logic             rst,          // async reset, high
    input  wire logic             ce,           // clock enable
    input  wire logic [3:0]       addr,         // register index
    input  wire logic [7:0]       wdata,        // write data
    input  wire logic             wr,           // write strobe
    input  wire logic             rd,           // read strobe
    output logic      [7:0]       rdata,        // read data, next cycle
    input  wire logic             cts_n,        // clear to send pin
    input  wire logic             dsr_n,        // data set ready pin
    input  wire logic             ring_indicator_n, // ring pin
    input  wire logic             carrier_detect_n, // carrier pin
    output logic                  rts_n,        // request to send pin
    output logic                  dtr_n,        // terminal ready pin
    output logic                  user_output_1_n, // user output 1
    output logic                  user_output_2_n, // user output 2
    output logic                  modem_irq,    // modem status interrupt
    output logic                  rx_trig_irq,  // auto rts trigger irq
    input  wire logic             rx_valid,     // received char strobe
    input  wire logic [7:0]       rx_char,      // received char
    input  wire logic [LVL_W-1:0] rx_level,     // rx fifo fill level
    input  wire logic [LVL_W-1:0] rx_trigger,   // programmed trigger
    input  wire logic             tx_char_done, // tx char boundary
    output logic                  tx_pause_r,   // tx held off
    output logic                  rx_remote_off // remote asked to pause
);
    initial begin
        if (LVL_W < 2 || LVL_W > 8) $error("ums_core: LVL_W out of range");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ien_r, ist_r, fctl_r, lctl_r, mctl_r;
    logic [7:0] scr_r, efc_r, res1_r, res2_r, pau1_r, pau2_r;
    logic [7:0] ien_sv_r, ist_sv_r, fctl_sv_r, mctl_sv_r;
    logic [3:0] delta_r;
    logic [3:0] pins_s;
    logic [3:0] pins_d_r;
    logic       rts_hold_r;
    logic       first_hit_r;
    logic       first_off_r;

    // pin order: 0 cts, 1 dsr, 2 ring, 3 carrier
    ums_sync #(
        .WIDTH (4),
        .INIT  (4'hF)
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .din   ({carrier_detect_n, ring_indicator_n, dsr_n, cts_n}),
        .dout  (pins_s)
    );

    wire logic loop_on  = mctl_r[ums_pkg::MCTL_LOOP];
    wire logic enh_on   = efc_r[ums_pkg::EFC_ENH];
    wire logic wr_mctl  = wr && addr == ums_pkg::ADDR_MCTL;
    wire logic wr_efc   = wr && addr == ums_pkg::ADDR_EFC;
    wire logic rd_mst   = rd && addr == ums_pkg::ADDR_MST;

    // status bits 4-7: active high pins or loopback outputs
    logic [3:0] mst_hi;
    assign mst_hi = loop_on ? {mctl_r[ums_pkg::MCTL_OUT2], mctl_r[ums_pkg::MCTL_OUT1],
                               mctl_r[ums_pkg::MCTL_DTR], mctl_r[ums_pkg::MCTL_RTS]} : ~pins_s;

    // ------------------------------------------------------------
    // modem change flags
    // ------------------------------------------------------------
    logic [3:0] chg;
    assign chg = {pins_s[3] ^ pins_d_r[3], pins_s[2] & ~pins_d_r[2], pins_s[1:0] ^ pins_d_r[1:0]};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins_d_r  <= 4'hF;
            delta_r   <= 4'h0;
            modem_irq <= 1'b0;
        end else if (ce) begin
            pins_d_r  <= pins_s;
            // set wins over the read clear
            delta_r   <= (rd_mst ? 4'h0 : delta_r) | chg;
            modem_irq <= |delta_r;
        end
    end

    // ------------------------------------------------------------
    // feature register with save and restore
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            efc_r <= ums_pkg::RST_ZERO;
        end else if (ce && wr_efc) begin
            efc_r <= wdata;
        end
    end

    // gated update of one register: enhanced lanes only while enabled
    function automatic logic [7:0] gated(input logic [7:0] cur, input logic [7:0] nw,
                                         input logic [7:0] msk, input logic en);
        gated = en ? nw : ((cur & msk) | (nw & ~msk));
    endfunction
    // enhanced bit transitions: falling saves and clears, rising restores
    wire logic enh_fall = wr_efc && enh_on && !wdata[ums_pkg::EFC_ENH];
    wire logic enh_rise = wr_efc && !enh_on && wdata[ums_pkg::EFC_ENH];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ien_sv_r  <= ums_pkg::RST_ZERO;
            ist_sv_r  <= ums_pkg::RST_ZERO;
            fctl_sv_r <= ums_pkg::RST_ZERO;
            mctl_sv_r <= ums_pkg::RST_ZERO;
        end else if (ce && enh_fall) begin
            ien_sv_r  <= ien_r & ums_pkg::IEN_ENH_MASK;
            ist_sv_r  <= ist_r & ums_pkg::IST_ENH_MASK;
            fctl_sv_r <= fctl_r & ums_pkg::FCTL_ENH_MASK;
            mctl_sv_r <= mctl_r & ums_pkg::MCTL_ENH_MASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ien_r  <= ums_pkg::RST_ZERO;
            fctl_r <= ums_pkg::RST_ZERO;
            mctl_r <= ums_pkg::RST_ZERO;
            lctl_r <= ums_pkg::RST_ZERO;
        end else if (ce) begin
            if (enh_fall) begin
                ien_r  <= ien_r & ~ums_pkg::IEN_ENH_MASK;
                fctl_r <= fctl_r & ~ums_pkg::FCTL_ENH_MASK;
                mctl_r <= mctl_r & ~ums_pkg::MCTL_ENH_MASK;
            end else if (enh_rise) begin
                ien_r  <= (ien_r & ~ums_pkg::IEN_ENH_MASK) | ien_sv_r;
                fctl_r <= (fctl_r & ~ums_pkg::FCTL_ENH_MASK) | fctl_sv_r;
                mctl_r <= (mctl_r & ~ums_pkg::MCTL_ENH_MASK) | mctl_sv_r;
            end else if (wr && addr == ums_pkg::ADDR_IEN) begin
                ien_r <= gated(ien_r, wdata, ums_pkg::IEN_ENH_MASK, enh_on);
            end else if (wr && addr == ums_pkg::ADDR_FCTL) begin
                fctl_r <= gated(fctl_r, wdata, ums_pkg::FCTL_ENH_MASK, enh_on);
            end else if (wr_mctl) begin
                mctl_r <= gated(mctl_r, wdata, ums_pkg::MCTL_ENH_MASK, enh_on);
            end else if (wr && addr == ums_pkg::ADDR_LCTL) begin
                lctl_r <= wdata;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scr_r  <= ums_pkg::RST_ZERO;
            res1_r <= ums_pkg::RST_ZERO;
            res2_r <= ums_pkg::RST_ZERO;
            pau1_r <= ums_pkg::RST_ZERO;
            pau2_r <= ums_pkg::RST_ZERO;
        end else if (ce && wr) begin
            if (addr == ums_pkg::ADDR_SCR) begin
                scr_r <= wdata;
            end else if (addr == ums_pkg::ADDR_RES1) begin
                res1_r <= wdata;
            end else if (addr == ums_pkg::ADDR_RES2) begin
                res2_r <= wdata;
            end else if (addr == ums_pkg::ADDR_PAU1) begin
                pau1_r <= wdata;
            end else if (addr == ums_pkg::ADDR_PAU2) begin
                pau2_r <= wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // receive character matching
    // ------------------------------------------------------------
    ums_pkg::ums_flow_t rx_mode;
    assign rx_mode = ums_pkg::ums_flow_t'(efc_r[1:0]);
    wire logic special = efc_r[ums_pkg::EFC_SPECIAL];

    // whole-byte compare keeps bit 0 aligned to the received lsb
    wire logic hit_p1 = rx_valid && rx_char == pau1_r;
    wire logic hit_p2 = rx_valid && rx_char == pau2_r;
    wire logic hit_r1 = rx_valid && rx_char == res1_r;
    wire logic hit_r2 = rx_valid && rx_char == res2_r;

    logic pause_seen, resume_seen;
    always_comb begin
        pause_seen  = 1'b0;
        resume_seen = 1'b0;
        case (rx_mode)
            ums_pkg::UMS_FLOW_FIRST: begin
                pause_seen  = hit_p1;
                resume_seen = hit_r1;
            end
            ums_pkg::UMS_FLOW_SECOND: begin
                pause_seen  = hit_p2;
                resume_seen = hit_r2;
            end
            ums_pkg::UMS_FLOW_BOTH: begin
                // two-character sequence: first then second
                pause_seen  = first_off_r && hit_p2;
                resume_seen = first_hit_r && hit_r2;
            end
            default: pause_seen = 1'b0;
        endcase
        // detection assumes software flow is off while enabled
        if (special && hit_p2) begin
            pause_seen = 1'b1;
        end
    end

    // sequence trackers for the dual mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_off_r <= 1'b0;
            first_hit_r <= 1'b0;
        end else if (ce && rx_valid) begin
            first_off_r <= hit_p1;
            first_hit_r <= hit_r1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ist_r <= ums_pkg::RST_IST;
        end else if (ce) begin
            if (enh_fall) begin
                ist_r <= ist_r & ~ums_pkg::IST_ENH_MASK;
            end else if (enh_rise) begin
                ist_r <= (ist_r & ~ums_pkg::IST_ENH_MASK) | ist_sv_r;
            end else if (enh_on && pause_seen) begin
                ist_r[ums_pkg::IST_XOFF] <= 1'b1;
            end else if (enh_on && resume_seen) begin
                ist_r[ums_pkg::IST_XOFF] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_remote_off <= 1'b0;
        end else if (ce) begin
            if (pause_seen && !special) begin
                rx_remote_off <= 1'b1;
            end else if (resume_seen) begin
                rx_remote_off <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // hardware flow control
    // ------------------------------------------------------------
    wire logic auto_rts = efc_r[ums_pkg::EFC_AUTO_RTS];
    wire logic auto_cts = efc_r[ums_pkg::EFC_AUTO_CTS];
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rts_hold_r  <= 1'b0;
            rx_trig_irq <= 1'b0;
        end else if (ce) begin
            rx_trig_irq <= auto_rts && rx_level >= rx_trigger;
            if (!auto_rts) begin
                rts_hold_r <= 1'b0;
            end else if (rx_level > rx_trigger) begin
                rts_hold_r <= 1'b1;
            end else if (rx_level < rx_trigger - LVL_W'(1)) begin
                rts_hold_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rts_n           <= 1'b1;
            dtr_n           <= 1'b1;
            user_output_1_n <= 1'b1;
            user_output_2_n <= 1'b1;
        end else if (ce) begin
            // pins go inactive in loopback, outputs fold back internally
            rts_n           <= loop_on || !mctl_r[ums_pkg::MCTL_RTS] || rts_hold_r;
            dtr_n           <= loop_on || !mctl_r[ums_pkg::MCTL_DTR];
            user_output_1_n <= loop_on || !mctl_r[ums_pkg::MCTL_OUT1];
            user_output_2_n <= loop_on || !mctl_r[ums_pkg::MCTL_OUT2];
        end
    end

    // pause only takes hold at a character boundary
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_pause_r <= 1'b0;
        end else if (ce) begin
            if (!auto_cts || mst_hi[0]) begin
                tx_pause_r <= 1'b0;
            end else if (tx_char_done) begin
                tx_pause_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read port; line status is the idle transmitter constant
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= ums_pkg::RST_ZERO;
        end else if (ce) begin
            if (!rd) begin
                rdata <= ums_pkg::RST_ZERO;
            end else if (addr == ums_pkg::ADDR_IEN) begin
                rdata <= ien_r;
            end else if (addr == ums_pkg::ADDR_IST) begin
                rdata <= ist_r;
            end else if (addr == ums_pkg::ADDR_LCTL) begin
                rdata <= lctl_r;
            end else if (addr == ums_pkg::ADDR_MCTL) begin
                rdata <= mctl_r;
            end else if (addr == ums_pkg::ADDR_LST) begin
                rdata <= ums_pkg::RST_LST;
            end else if (addr == ums_pkg::ADDR_MST) begin
                rdata <= {mst_hi, delta_r};
            end else if (addr == ums_pkg::ADDR_SCR) begin
                rdata <= scr_r;
            end else if (addr == ums_pkg::ADDR_EFC) begin
                rdata <= efc_r;
            end else if (addr == ums_pkg::ADDR_RES1) begin
                rdata <= res1_r;
            end else if (addr == ums_pkg::ADDR_RES2) begin
                rdata <= res2_r;
            end else if (addr == ums_pkg::ADDR_PAU1) begin
                rdata <= pau1_r;
            end else if (addr == ums_pkg::ADDR_PAU2) begin
                rdata <= pau2_r;
            end else if (addr == ums_pkg::ADDR_FLOW) begin
                rdata <= {4'h0, fctl_r[0], rts_hold_r, tx_pause_r, rx_remote_off};
            end else begin
                rdata <= ums_pkg::RST_ZERO;
            end
        end
    end
endmodule

// file: testbench/ums_core_monitor.sv
// ums_core_monitor: port-level assertions for ums_core.
// assumes: bound to ums_core, clock enable held high.
`timescale 1ns/1ps
module ums_core_monitor #(
    parameter int LVL_W = 5
) (
    input wire logic             clock,        // clock
    input wire logic             rst,          // async reset
    input wire logic [3:0]       addr,         // register index
    input wire logic             wr,           // write strobe
    input wire logic             rd,           // read strobe
    input wire logic [7:0]       rdata,        // read data
    input wire logic             cts_n,        // clear to send pin
    input wire logic             dsr_n,        // data set ready pin
    input wire logic             modem_irq,    // modem interrupt
    input wire logic             rx_trig_irq,  // trigger interrupt
    input wire logic [LVL_W-1:0] rx_level,     // fifo level
    input wire logic [LVL_W-1:0] rx_trigger,   // trigger level
    input wire logic             tx_char_done, // char boundary
    input wire logic             tx_pause_r    // tx hold
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
    line_stat_a: assert property (rd && addr == ums_pkg::ADDR_LST |=> rdata == ums_pkg::RST_LST)
        else $error("line status wrong");
    irq_flag_a: assert property ($past(rd && addr == ums_pkg::ADDR_MST) && rdata[3:0] != 4'h0 |-> modem_irq)
        else $error("flag without irq");
    irq_change_a: assert property ($changed(cts_n) || $changed(dsr_n) |-> ##[2:6] (modem_irq || rd))
        else $error("change missed");
    irq_drop_a: assert property ($fell(modem_irq) |-> $past(rd && addr == ums_pkg::ADDR_MST, 2))
        else $error("irq dropped without read");
    trig_level_a: assert property (rx_trig_irq |-> $past(rx_level >= rx_trigger))
        else $error("trigger irq early");
    pause_start_a: assert property ($rose(tx_pause_r) |-> $past(tx_char_done))
        else $error("pause mid char");
    pause_end_a: assert property ($fell(tx_pause_r) |-> $past(wr, 2) || !$past(cts_n, 2) || !$past(cts_n, 3))
        else $error("pause ended early");
    cover property ($rose(modem_irq));
    cover property ($rose(tx_pause_r));
    cover property ($rose(rx_trig_irq));
endmodule

bind ums_core ums_core_monitor #(.LVL_W(LVL_W)) u_mon (.clock(clock), .rst(rst), .addr(addr), .wr(wr),
    .rd(rd), .rdata(rdata), .cts_n(cts_n), .dsr_n(dsr_n), .modem_irq(modem_irq), .rx_trig_irq(rx_trig_irq),
    .rx_level(rx_level), .rx_trigger(rx_trigger), .tx_char_done(tx_char_done), .tx_pause_r(tx_pause_r));

// file: testbench/ums_modem_model.sv
// ums_modem_model: far-side modem pins and character pacing.
// assumes: active lines are high-true requests from the bench.
`timescale 1ns/1ps
module ums_modem_model #(
    parameter int GAP = 4
) (
    input  wire logic       clock,            // clock
    input  wire logic       rst,              // async reset
    input  wire logic [3:0] active,           // cts, dsr, ring, cd asserted
    input  wire logic       tx_pause_r,       // hold from block
    output logic            cts_n,            // clear to send pin
    output logic            dsr_n,            // data set ready pin
    output logic            ring_indicator_n, // ring pin
    output logic            carrier_detect_n, // carrier pin
    output logic            tx_char_done      // char boundary
);
    int cnt;
    // pins move off the edge, as an unrelated modem would
    assign #3 {carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = ~active;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt          <= 0;
            tx_char_done <= 1'b0;
        end else begin
            cnt          <= (cnt == GAP - 1) ? 0 : cnt + 1;
            tx_char_done <= (cnt == GAP - 1) && !tx_pause_r;
        end
    end
endmodule

// file: testbench/uart_modem_status_flow_control_bench.sv
// bench: register table, modem pins, loopback, auto rts/cts, pause chars.
// assumes: ums_core with bound monitor, modem model on the pins.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module uart_modem_status_flow_control_bench;
    typedef struct {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} ums_row_t;
    logic       clock, rst, wr, rd, rx_valid, txd, rts_n, dtr_n, irq, trig, pause, roff, op1_n, op2_n;
    logic       cts_n, dsr_n, ri_n, cd_n;
    logic [3:0] addr, act;
    logic [7:0] wdata, rdata, rx_char, v;
    logic [4:0] rx_level;
    int         failures, n_tests;
    ums_row_t   rows[20] = '{'{0,4'h1,0,8'h00}, '{0,4'h2,0,8'h01}, '{0,4'h3,0,8'h00}, '{0,4'h4,0,8'h00},
        '{0,4'h5,0,8'h60}, '{0,4'h6,0,8'h00}, '{0,4'h8,0,8'h00}, '{1,4'h7,8'h5A,8'h5A}, '{1,4'h7,8'hA5,8'hA5},
        '{1,4'h4,8'hE3,8'h03}, '{1,4'h1,8'hF1,8'h01}, '{1,4'h8,8'h10,8'h10}, '{1,4'h4,8'hE3,8'hE3},
        '{1,4'h8,8'h00,8'h00}, '{0,4'h4,0,8'h03}, '{1,4'h8,8'h10,8'h10}, '{0,4'h4,0,8'hE3},
        '{1,4'hB,8'h13,8'h13}, '{1,4'hC,8'h93,8'h93}, '{1,4'hF,8'hFF,8'h00}};
    logic [3:0] pins[5] = '{4'h1, 4'h5, 4'h1, 4'hB, 4'h0};
    logic [7:0] pexp[5] = '{8'h11, 8'h50, 8'h14, 8'hBA, 8'h0B};
    logic [4:0] lvl[3] = '{5'h09, 5'h07, 5'h06};
    ums_core DUT (.clock(clock), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cts_n(cts_n), .dsr_n(dsr_n), .ring_indicator_n(ri_n), .carrier_detect_n(cd_n), .rts_n(rts_n),
        .dtr_n(dtr_n), .user_output_1_n(op1_n), .user_output_2_n(op2_n), .modem_irq(irq), .rx_trig_irq(trig),
        .rx_valid(rx_valid), .rx_char(rx_char), .rx_level(rx_level), .rx_trigger(5'h08), .tx_char_done(txd),
        .tx_pause_r(pause), .rx_remote_off(roff));
    ums_modem_model MDM (.clock(clock), .rst(rst), .active(act), .tx_pause_r(pause), .cts_n(cts_n),
        .dsr_n(dsr_n), .ring_indicator_n(ri_n), .carrier_detect_n(cd_n), .tx_char_done(txd));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rx_chk(input logic [7:0] c, input logic e);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_char  <= c;
        @(posedge clock);
        rx_valid <= 1'b0;
        rd_reg(4'h2);
        `CHK(v[4], e)
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        complete_run;
    end
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {rst, wr, rd, rx_valid, addr, wdata, rx_char, rx_level, act} = {1'b1, 32'h0};
        failures = 0;
        n_tests  = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a);
            `CHK(v, rows[i].e)
        end
        $display("register table done");
        foreach (pins[i]) begin
            @(posedge clock);
            act <= pins[i];
            wt(6);
            `CHK(irq, pexp[i][3:0] != 4'h0)
            rd_reg(4'h6);
            `CHK(v, pexp[i])
            rd_reg(4'h6);
            `CHK(v, pexp[i] & 8'hF0)
        end
        $display("modem pins done");
        wr_reg(4'h4, 8'h1F);
        rd_reg(4'h6);
        `CHK({v[7:4], rts_n, dtr_n}, 6'h3F)
        wr_reg(4'h4, 8'h16);
        rd_reg(4'h6);
        `CHK(v[7:4], 4'h5)
        wr_reg(4'h4, 8'h06);
        wt(3);
        `CHK({rts_n, dtr_n, op1_n, op2_n}, 4'b0101)
        $display("loopback done");
        wr_reg(4'h8, 8'h50);
        foreach (lvl[i]) begin
            @(posedge clock);
            rx_level <= lvl[i];
            wt(4);
            `CHK({rts_n, trig}, {i < 2, i == 0})
        end
        $display("auto rts done");
        wr_reg(4'h8, 8'h90);
        wt(10);
        `CHK(pause, 1'b1)
        @(posedge clock);
        act <= 4'h1;
        wt(6);
        `CHK(pause, 1'b0)
        $display("auto cts done");
        wr_reg(4'h8, 8'h13);
        rx_chk(8'h93, 1'b0);
        rx_chk(8'h13, 1'b0);
        rx_chk(8'h93, 1'b1);
        `CHK(roff, 1'b1)
        rx_chk(8'h00, 1'b1);
        rx_chk(8'h00, 1'b0);
        wr_reg(4'h8, 8'h30);
        rx_chk(8'h92, 1'b0);
        rx_chk(8'h93, 1'b1);
        $display("pause chars done");
        complete_run;
    end
endmodule
